// file: verilog/lacr_top.v
// lacr_top.v - legacy ATA compatibility registers of a SATA controller:
// APB register bank for both controller functions, per-channel I/O
// decode gating, hot-plug notification and link low-power permission.
// assumes: all inputs except nrst synchronous to clk; native BAR values come from
// the function's own config space; APB4 master with byte strobes.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "lacr_map.vh"

module lacr_top (
    input  wire        clk,            // 125 MHz core clock
    input  wire        nrst,           // async reset, active low
    input  wire        ce,             // clock enable, freezes state
    input  wire        psel,           // APB select
    input  wire        penable,        // APB access phase
    input  wire        pwrite,         // APB direction, 1 = write
    input  wire [11:0] paddr,          // APB byte address
    input  wire [31:0] pwdata,         // APB write data
    input  wire [3:0]  pstrb,          // APB byte strobes
    output reg  [31:0] prdata,         // APB read data
    output wire        pready,         // APB ready
    output wire        pslverr,        // APB error, unmapped address
    input  wire        io_valid,       // I/O cycle present
    input  wire [15:0] io_addr,        // I/O cycle address
    input  wire [1:0]  native_mode,    // per channel native mode
    input  wire [31:0] native_cmd_base,// {sec,pri} command BARs
    input  wire [31:0] native_ctl_base,// {sec,pri} control BARs
    output reg  [1:0]  io_claim_cmd,   // per channel command claim
    output reg  [1:0]  io_claim_ctl,   // per channel control claim
    input  wire [1:0]  drive_present,  // per port presence
    output reg  [1:0]  lp_allow,       // per port PARTIAL/SLUMBER ok
    output wire        irq             // level interrupt
);

////////////////////////////////////////////////////////////////////////
// register storage

reg  [15:0] channel_timing_pri;
reg  [15:0] channel_timing_sec;
reg  [7:0]  slave_drive_timing_pri;
reg  [7:0]  sync_dma_control_pri;
reg  [7:0]  sync_dma_control_sec;
reg  [15:0] sync_dma_timing_pri;
reg  [15:0] sync_dma_timing_sec;
reg  [31:0] io_config_pri;
reg  [31:0] io_config_sec;
reg  [7:0]  hp_control;
reg  [3:0]  hp_status;
reg  [3:0]  hp_mask;
reg  [1:0]  pres_q;
reg         primed;

////////////////////////////////////////////////////////////////////////
// APB decode

wire [1:0]  fn  = paddr[`LACR_FN_MSB:`LACR_FN_LSB];
wire [7:0]  idx = paddr[`LACR_IDX_MSB:`LACR_IDX_LSB];
wire [31:0] wm  = {{8{pstrb[3]}}, {8{pstrb[2]}},
                   {8{pstrb[1]}}, {8{pstrb[0]}}};
wire        wr  = psel & penable & pwrite & ce;

wire sel_ct_p    = (fn == `LACR_FN_PRI) && (idx == `LACR_IDX_CT);
wire sel_ct_s    = (fn == `LACR_FN_SEC) && (idx == `LACR_IDX_CT);
wire sel_sdt_p   = (fn == `LACR_FN_PRI) && (idx == `LACR_IDX_SDT);
wire sel_sdc_p   = (fn == `LACR_FN_PRI) && (idx == `LACR_IDX_SDC);
wire sel_sdc_s   = (fn == `LACR_FN_SEC) && (idx == `LACR_IDX_SDC);
wire sel_sdtim_p = (fn == `LACR_FN_PRI) && (idx == `LACR_IDX_SDTIM);
wire sel_sdtim_s = (fn == `LACR_FN_SEC) && (idx == `LACR_IDX_SDTIM);
wire sel_iocfg_p = (fn == `LACR_FN_PRI) && (idx == `LACR_IDX_IOCFG);
wire sel_iocfg_s = (fn == `LACR_FN_SEC) && (idx == `LACR_IDX_IOCFG);
wire sel_hpctl   = (fn == `LACR_FN_HP)  && (idx == `LACR_IDX_HPCTL);
wire sel_hpsts   = (fn == `LACR_FN_HP)  && (idx == `LACR_IDX_HPSTS);
wire sel_hpmsk   = (fn == `LACR_FN_HP)  && (idx == `LACR_IDX_HPMSK);

wire hit = sel_ct_p | sel_ct_s | sel_sdt_p | sel_sdc_p | sel_sdc_s |
           sel_sdtim_p | sel_sdtim_s | sel_iocfg_p | sel_iocfg_s |
           sel_hpctl | sel_hpsts | sel_hpmsk;

// zero wait states: read data is captured during the setup cycle
assign pready  = ce;
assign pslverr = psel & penable & ~hit;

////////////////////////////////////////////////////////////////////////
// read mux; unlisted bits are never stored so they read as zero

reg [31:0] next_prdata;

always @* begin
    next_prdata = `LACR_RST_32;
    if (sel_ct_p)
        next_prdata = {16'h0000, channel_timing_pri};
    else if (sel_ct_s)
        next_prdata = {16'h0000, channel_timing_sec};
    else if (sel_sdt_p)
        next_prdata = {24'h000000, slave_drive_timing_pri};
    else if (sel_sdc_p)
        next_prdata = {24'h000000, sync_dma_control_pri};
    else if (sel_sdc_s)
        next_prdata = {24'h000000, sync_dma_control_sec};
    else if (sel_sdtim_p)
        next_prdata = {16'h0000, sync_dma_timing_pri};
    else if (sel_sdtim_s)
        next_prdata = {16'h0000, sync_dma_timing_sec};
    else if (sel_iocfg_p)
        next_prdata = io_config_pri;
    else if (sel_iocfg_s)
        next_prdata = io_config_sec;
    else if (sel_hpctl)
        next_prdata = {24'h000000, hp_control};
    else if (sel_hpsts)
        next_prdata = {26'h0000000, pres_q, hp_status};
    else if (sel_hpmsk)
        next_prdata = {28'h0000000, hp_mask};
end

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        prdata <= `LACR_RST_32;
    end else if (ce && psel && !penable && !pwrite) begin
        prdata <= next_prdata;
    end
end

////////////////////////////////////////////////////////////////////////
// storage registers; each write keeps unstrobed and reserved bits

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        channel_timing_pri     <= `LACR_RST_CT;
        channel_timing_sec     <= `LACR_RST_CT;
        slave_drive_timing_pri <= `LACR_RST_8;
        sync_dma_control_pri   <= `LACR_RST_8;
        sync_dma_control_sec   <= `LACR_RST_8;
        sync_dma_timing_pri    <= `LACR_RST_16;
        sync_dma_timing_sec    <= `LACR_RST_16;
        io_config_pri          <= `LACR_RST_32;
        io_config_sec          <= `LACR_RST_32;
        hp_control             <= `LACR_RST_8;
        hp_mask                <= 4'h0;
    end else if (wr) begin
        if (sel_ct_p)
            channel_timing_pri <= (channel_timing_pri & ~wm[15:0])
                | (pwdata[15:0] & wm[15:0] & `LACR_CT_MASK);
        if (sel_ct_s)
            channel_timing_sec <= (channel_timing_sec & ~wm[15:0])
                | (pwdata[15:0] & wm[15:0] & `LACR_CT_MASK);
        if (sel_sdt_p && pstrb[0])
            slave_drive_timing_pri <= pwdata[7:0] & `LACR_SDT_MASK;
        if (sel_sdc_p && pstrb[0])
            sync_dma_control_pri <= pwdata[7:0] & `LACR_SDC_MASK;
        if (sel_sdc_s && pstrb[0])
            sync_dma_control_sec <= pwdata[7:0] & `LACR_SDC_MASK;
        if (sel_sdtim_p)
            sync_dma_timing_pri <= (sync_dma_timing_pri & ~wm[15:0])
                | (pwdata[15:0] & wm[15:0] & `LACR_SDTIM_PRI_MASK);
        if (sel_sdtim_s)
            sync_dma_timing_sec <= (sync_dma_timing_sec & ~wm[15:0])
                | (pwdata[15:0] & wm[15:0] & `LACR_SDTIM_SEC_MASK);
        if (sel_iocfg_p)
            io_config_pri <= (io_config_pri & ~wm)
                | (pwdata & wm & `LACR_IOCFG_PRI_MASK);
        if (sel_iocfg_s)
            io_config_sec <= (io_config_sec & ~wm)
                | (pwdata & wm & `LACR_IOCFG_SEC_MASK);
        if (sel_hpctl && pstrb[0])
            hp_control <= pwdata[7:0] & `LACR_HPCTL_MASK;
        if (sel_hpmsk && pstrb[0])
            hp_mask <= pwdata[3:0] & `LACR_EV_MASK;
    end
end

////////////////////////////////////////////////////////////////////////
// per-channel I/O decode and per-port hot-plug

wire [1:0] dec_en = {channel_timing_sec[`LACR_CT_DEC_BIT],
                     channel_timing_pri[`LACR_CT_DEC_BIT]};
wire [1:0] hp_en  = hp_control[1:0];
wire [1:0] mps    = hp_control[`LACR_HPCTL_MPS_LSB+1:`LACR_HPCTL_MPS_LSB];
wire [1:0] ev_ins;
wire [1:0] ev_rem;
wire [1:0] next_claim_cmd;
wire [1:0] next_claim_ctl;
wire [1:0] next_lp_allow;

genvar ch;
generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
        wire [15:0] leg_cmd = (ch == 0) ? `LACR_CMD_PRI : `LACR_CMD_SEC;
        wire [15:0] leg_ctl = (ch == 0) ? `LACR_CTL_PRI : `LACR_CTL_SEC;
        wire [15:0] nat_cmd = native_cmd_base[16*ch+15:16*ch];
        wire [15:0] nat_ctl = native_ctl_base[16*ch+15:16*ch];
        wire leg_cmd_hit = io_addr[15:`LACR_CMD_LSB]
                           == leg_cmd[15:`LACR_CMD_LSB];
        wire leg_ctl_hit = io_addr == leg_ctl;
        wire nat_cmd_hit = io_addr[15:`LACR_CMD_LSB]
                           == nat_cmd[15:`LACR_CMD_LSB];
        wire nat_ctl_hit = (io_addr[15:`LACR_CTL_LSB]
                           == nat_ctl[15:`LACR_CTL_LSB])
                           && (io_addr[1:0] == `LACR_CTL_BYTE);
        // the one enable bit gates both address styles
        assign next_claim_cmd[ch] = io_valid & dec_en[ch]
            & (native_mode[ch] ? nat_cmd_hit : leg_cmd_hit);
        assign next_claim_ctl[ch] = io_valid & dec_en[ch]
            & (native_mode[ch] ? nat_ctl_hit : leg_ctl_hit);
        // edges are ignored until one sample is held after reset
        assign ev_ins[ch] = primed & hp_en[ch]
                            & drive_present[ch] & ~pres_q[ch];
        assign ev_rem[ch] = primed & hp_en[ch]
                            & ~drive_present[ch] & pres_q[ch];
        // without a switch the link must stay up to see a removal
        assign next_lp_allow[ch] = mps[ch] | ~hp_en[ch];
    end
endgenerate

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        io_claim_cmd <= 2'h0;
        io_claim_ctl <= 2'h0;
        lp_allow     <= 2'h0;
        pres_q       <= 2'h0;
        primed       <= 1'b0;
    end else if (ce) begin
        io_claim_cmd <= next_claim_cmd;
        io_claim_ctl <= next_claim_ctl;
        lp_allow     <= next_lp_allow;
        pres_q       <= drive_present;
        primed       <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// sticky event status, write one to clear; a new event beats the clear

wire [3:0] ev_vec  = {ev_rem, ev_ins};
wire [3:0] clr_vec = (wr && sel_hpsts && pstrb[0]) ?
                     pwdata[3:0] : 4'h0;

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        hp_status <= 4'h0;
    end else if (ce) begin
        hp_status <= (hp_status & ~clr_vec) | ev_vec;
    end
end

assign irq = |(hp_status & hp_mask);

endmodule // lacr_top

`default_nettype wire

// file: verilog/lacr_map.vh
// lacr_map.vh - address map, field masks and reset values of the legacy
// ATA compatibility register bank.
// assumes: included by lacr_top.v only; APB byte addresses, 32-bit data.
`ifndef LACR_MAP_VH
`define LACR_MAP_VH

// paddr[11:10] selects the function space, paddr[9:2] the register index
`define LACR_FN_MSB     11
`define LACR_FN_LSB     10
`define LACR_IDX_MSB    9
`define LACR_IDX_LSB    2
`define LACR_FN_PRI     2'h0
`define LACR_FN_SEC     2'h1
`define LACR_FN_HP      2'h2

// register indices (byte address = 4 * index)
`define LACR_IDX_CT     8'h40
`define LACR_IDX_SDT    8'h44
`define LACR_IDX_SDC    8'h48
`define LACR_IDX_SDTIM  8'h4A
`define LACR_IDX_IOCFG  8'h54
`define LACR_IDX_HPCTL  8'h00
`define LACR_IDX_HPSTS  8'h01
`define LACR_IDX_HPMSK  8'h02

// writable bits per register; all other bits are reserved
`define LACR_CT_MASK        16'hF3FF
`define LACR_CT_DEC_BIT     15
`define LACR_SDT_MASK       8'hFF
`define LACR_SDC_MASK       8'h0F
`define LACR_SDTIM_PRI_MASK 16'h3333
`define LACR_SDTIM_SEC_MASK 16'h0303
`define LACR_IOCFG_PRI_MASK 32'h00FFF0FF
`define LACR_IOCFG_SEC_MASK 32'h00FF50F5
`define LACR_HPCTL_MASK     8'h33
`define LACR_HPCTL_MPS_LSB  4
`define LACR_EV_MASK        4'hF
`define LACR_PRES_LSB       4

// reset values
`define LACR_RST_CT     16'h0000
`define LACR_RST_8      8'h00
`define LACR_RST_16     16'h0000
`define LACR_RST_32     32'h00000000

// legacy I/O ranges
`define LACR_CMD_PRI    16'h01F0
`define LACR_CTL_PRI    16'h03F6
`define LACR_CMD_SEC    16'h0170
`define LACR_CTL_SEC    16'h0376
`define LACR_CMD_LSB    3
`define LACR_CTL_LSB    2
`define LACR_CTL_BYTE   2'h2

`endif

// file: testbench/lacr_monitor.sv
// lacr_monitor.sv - port assertions for the compatibility register bank.
// assumes: bound to lacr_top; one clock domain, nrst async active low.
`timescale 1ns/1ns
`default_nettype none
module lacr_monitor (
    input wire        clk,             // core clock
    input wire        nrst,            // reset, active low
    input wire        ce,              // clock enable
    input wire        psel,            // apb select
    input wire        penable,         // apb access phase
    input wire        pwrite,          // apb direction
    input wire [11:0] paddr,           // apb address
    input wire [31:0] prdata,          // apb read data
    input wire        pslverr,         // apb error
    input wire        io_valid,        // io cycle present
    input wire [15:0] io_addr,         // io address
    input wire [1:0]  native_mode,     // native mode per channel
    input wire [31:0] native_cmd_base, // command bases
    input wire [31:0] native_ctl_base, // control bases
    input wire [1:0]  io_claim_cmd,    // command claims
    input wire [1:0]  io_claim_ctl,    // control claims
    input wire        irq              // interrupt
);
default clocking cb @(posedge clk); endclocking
default disable iff (!nrst);
wire rd = psel && penable && !pwrite;
// reads are judged in the access phase, where prdata is presented
err_in_access_a: assert property (
    pslverr |-> psel && penable) else $error("pslverr outside access");
cmd_claim_src_a: assert property (
    io_claim_cmd[0] && $past(ce) |-> $past(io_valid) &&
    ($past(io_addr[15:3]) == 13'h003E || $past(native_mode[0]) &&
    $past(io_addr[15:3]) == $past(native_cmd_base[15:3])))
    else $error("primary command claim without cause");
ctl_claim_src_a: assert property (
    io_claim_ctl[0] && $past(ce) |-> $past(io_valid) &&
    ($past(io_addr) == 16'h03F6 || $past(native_mode[0]) &&
    $past(io_addr) == $past(native_ctl_base[15:0]) + 16'h0002))
    else $error("primary control claim without cause");
timing_rsvd_a: assert property (
    rd && paddr[9:0] == 10'h100 |-> (prdata & 32'hFFFF0C00) == 32'h0)
    else $error("timing reserved bits set");
slave_rsvd_a: assert property (
    rd && paddr == 12'h110 |-> prdata[31:8] == 24'h0)
    else $error("slave timing upper bits set");
dma_ctl_rsvd_a: assert property (
    rd && paddr[9:0] == 10'h120 |-> prdata[31:4] == 28'h0)
    else $error("dma control reserved bits set");
dtim_pri_a: assert property (
    rd && paddr == 12'h128 |-> (prdata & 32'hFFFFCCCC) == 32'h0)
    else $error("primary dma timing reserved bits set");
dtim_sec_a: assert property (
    rd && paddr == 12'h528 |-> (prdata & 32'hFFFFFCFC) == 32'h0)
    else $error("secondary dma timing reserved bits set");
iocfg_pri_a: assert property (
    rd && paddr == 12'h150 |-> (prdata & 32'hFF000F00) == 32'h0)
    else $error("primary io config reserved bits set");
cover property (rd && paddr == 12'h804);
cover property (io_claim_cmd[0]);
cover property ($rose(irq));
endmodule // lacr_monitor
bind lacr_top lacr_monitor u_mon (
    .clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .io_valid(io_valid), .io_addr(io_addr), .native_mode(native_mode),
    .native_cmd_base(native_cmd_base), .native_ctl_base(native_ctl_base),
    .io_claim_cmd(io_claim_cmd), .io_claim_ctl(io_claim_ctl), .irq(irq)
);
`default_nettype wire

// file: testbench/legacy_ata_compat_regs_tb.sv
// legacy_ata_compat_regs_tb.sv - self-checking bench for lacr_top.
// assumes: pready follows ce, so ce is held high throughout.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module legacy_ata_compat_regs_tb;
logic        clk = 1'b0, nrst = 1'b0, io_valid = 1'b0;
logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, ncmd = 32'h30001000, nctl = 32'h40002000;
logic [15:0] io_addr = 16'h0000;
logic [1:0]  nmode = 2'b00, present = 2'b00;
wire  [31:0] prdata;
wire         pready, pslverr, irq;
wire  [1:0]  claim_cmd, claim_ctl, lp_allow;
int          fail_count = 0, compares = 0;
localparam logic [11:0] RA [9] = '{12'h100, 12'h500, 12'h110, 12'h120,
    12'h520, 12'h128, 12'h528, 12'h150, 12'h550};
localparam logic [31:0] RM [9] = '{32'hF3FF, 32'hF3FF, 32'hFF, 32'h0F,
    32'h0F, 32'h3333, 32'h0303, 32'h00FFF0FF, 32'h00FF50F5};
always #4 clk = ~clk;
lacr_top DUT (
    .clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_valid(io_valid), .io_addr(io_addr), .native_mode(nmode),
    .native_cmd_base(ncmd), .native_ctl_base(nctl),
    .io_claim_cmd(claim_cmd), .io_claim_ctl(claim_ctl),
    .drive_present(present), .lp_allow(lp_allow), .irq(irq)
);
////////////////////////////////////////////////////////////////////////////
task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
// each transfer starts on an edge, so back-to-back calls leave one idle
task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d, output logic [32:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
        @(posedge clk);
        n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
        fail_count++;
        finish_test();
    end
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] q;
    apb(a, 1'b1, d, q);
endtask
task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
    input logic ee);
    logic [32:0] q;
    apb(a, 1'b0, 32'h0, q);
    `CHK(q, {ee, e})
endtask
task automatic io(input logic [15:0] a, input logic [3:0] e);
    @(posedge clk);
    io_valid <= 1'b1;
    io_addr <= a;
    @(posedge clk);
    io_valid <= 1'b0;
    #1;
    `CHK({claim_ctl, claim_cmd}, e)
endtask
////////////////////////////////////////////////////////////////////////////
task automatic t_regs();
    for (int i = 0; i < 9; i++) begin
        rd_chk(RA[i], 32'h0, 1'b0);
        wr(RA[i], 32'hFFFFFFFF);
        rd_chk(RA[i], RM[i], 1'b0);
        wr(RA[i], 32'h0);
    end
    rd_chk(12'h510, 32'h0, 1'b1);
    $display("test regs done");
endtask
task automatic t_dec();
    io(16'h01F3, 4'h0);
    wr(12'h100, 32'h8000);
    wr(12'h500, 32'h8000);
    io(16'h01F0, 4'h1);
    io(16'h01F7, 4'h1);
    io(16'h01F8, 4'h0);
    io(16'h03F6, 4'h4);
    io(16'h03F7, 4'h0);
    io(16'h0170, 4'h2);
    io(16'h0376, 4'h8);
    wr(12'h500, 32'h0);
    io(16'h0172, 4'h0);
    // storage fields set beside the enable must not disturb decode
    wr(12'h100, 32'hF3FF);
    nmode <= 2'b01;
    io(16'h1004, 4'h1);
    io(16'h2002, 4'h4);
    wr(12'h100, 32'h73FF);
    io(16'h1004, 4'h0);
    $display("test decode done");
endtask
task automatic t_hp();
    wr(12'h808, 32'h1);
    wr(12'h800, 32'h1);
    @(posedge clk);
    #1;
    `CHK(lp_allow, 2'b10)
    wr(12'h800, 32'h11);
    @(posedge clk);
    #1;
    `CHK(lp_allow, 2'b11)
    @(posedge clk);
    present <= 2'b01;
    repeat (3) @(posedge clk);
    #1;
    `CHK(irq, 1'b1)
    rd_chk(12'h804, 32'h11, 1'b0);
    present <= 2'b00;
    wr(12'h804, 32'h1);
    #1;
    `CHK(irq, 1'b0)
    rd_chk(12'h804, 32'h4, 1'b0);
    wr(12'h808, 32'hF);
    #1;
    `CHK(irq, 1'b1)
    wr(12'h804, 32'hF);
    present <= 2'b10;
    repeat (3) @(posedge clk);
    #1;
    `CHK(irq, 1'b0)
    rd_chk(12'h804, 32'h20, 1'b0);
    $display("test hotplug done");
endtask
initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_dec();
    t_hp();
    finish_test();
end
endmodule // legacy_ata_compat_regs_tb
`default_nettype wire
